// [src/wwdg_cfg.svh]
`ifndef WWDG_CFG_SVH
`define WWDG_CFG_SVH
`define WWDG_AW           8
`define WWDG_CTRL_IDX     8'h2F
`define WWDG_WIN_IDX      8'h30
`define WWDG_CTRL_RST     8'h7F
`define WWDG_WIN_RST      7'h7F
`define WWDG_ACT_BIT      7
`define WWDG_TOP_BIT      6
`define WWDG_ROLL_VAL     7'h40
`define WWDG_PRESC_DIV    16384
`define WWDG_CLK_NS       50
`define WWDG_RST_PULSE_NS 30000
`define WWDG_RST_PULSE_CYC ((`WWDG_RST_PULSE_NS + `WWDG_CLK_NS - 1) / `WWDG_CLK_NS)
`define WWDG_WAKE_SHORT   256
`define WWDG_WAKE_LONG    4096
`define WWDG_RESP_OKAY    2'h0
`define WWDG_RESP_SLVERR  2'h2
`endif

// [src/wwdg_pkg.sv]
package wwdg_pkg;
  typedef logic [31:0] wwdg_word_t;
  typedef logic [7:0]  wwdg_addr_t;
  // gray codes along run -> halt -> wake -> run
  typedef enum logic [2:0] {
    WWDG_RUN      = 3'h0,
    WWDG_HALT_DEC = 3'h1,
    WWDG_HALTED   = 3'h3,
    WWDG_WAKE_DLY = 3'h2,
    WWDG_ACT_HALT = 3'h4
  } wwdg_state_t;
endpackage : wwdg_pkg

// [src/wwdg_if.sv]
`timescale 1ns/1ns
interface wwdg_if;
  logic run;
  logic tick;
  logic fire;
  logic busy;
  modport presc  (input run, output tick);
  modport rstgen (input fire, output busy);
  modport core   (output run, output fire, input tick, input busy);
endinterface : wwdg_if

// [src/wwdg_presc.sv]
`timescale 1ns/1ns
module wwdg_presc #(
  parameter int DIV = 16384
) (
  input wire logic ref_clk,
  input wire logic rst,
  wwdg_if.presc    pif
);
  import wwdg_pkg::*;
  localparam int W = $clog2(DIV);
  logic [W-1:0] div_r;
  logic         wrap;

  // the phase only freezes, it is never cleared by a counter write
  assign wrap     = (div_r == W'(DIV - 1));
  assign pif.tick = pif.run && wrap;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else if (pif.run) begin
      div_r <= wrap ? '0 : div_r + 1'b1;
    end
  end

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    pif.tick |=> !pif.tick [*8])
    else $error("prescaler ticks too close");
endmodule : wwdg_presc

// [src/wwdg_rstgen.sv]
`timescale 1ns/1ns
`include "wwdg_cfg.svh"
module wwdg_rstgen (
  input  wire logic ref_clk,
  input  wire logic rst,
  wwdg_if.rstgen    rif,
  output logic      rst_pin_o,
  output logic      rst_pin_oe
);
  import wwdg_pkg::*;
  localparam int PULSE = `WWDG_RST_PULSE_CYC;
  logic [9:0] len_r;
  logic       busy_r;

  assign rif.busy   = busy_r;
  assign rst_pin_oe = busy_r;
  assign rst_pin_o  = 1'b0; // open drain, only ever pulls low

  // further requests during a pulse merge into it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      len_r  <= '0;
    end else if (!busy_r) begin
      busy_r <= rif.fire;
      len_r  <= '0;
    end else begin
      busy_r <= (len_r != 10'(PULSE - 1));
      len_r  <= len_r + 1'b1;
    end
  end

  // the 600-cycle pulse is judged through its own counter, far too long to unroll
  a_pulse_held: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(busy_r) |-> len_r == 10'(PULSE))
    else $error("reset pulse length wrong");
  a_pulse_bound: assert property (@(posedge ref_clk) disable iff (rst)
    busy_r |-> len_r < 10'(PULSE))
    else $error("reset pulse overran");
endmodule : wwdg_rstgen

// [src/wwdg_top.sv]
`timescale 1ns/1ns
`include "wwdg_cfg.svh"
module wwdg_top #(
  parameter int PRESC_DIV = `WWDG_PRESC_DIV
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire wwdg_pkg::wwdg_addr_t s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire wwdg_pkg::wwdg_word_t s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire wwdg_pkg::wwdg_addr_t s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output wwdg_pkg::wwdg_word_t s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            hw_wdg_option,
  input  wire logic            reset_on_halt_option,
  input  wire logic            halt_exec,
  input  wire logic            clock_timer_irq_enable,
  input  wire logic            ext_irq,
  input  wire logic            osc_irq,
  input  wire logic            wake_delay_long,
  output logic                 rst_pin_o,
  output logic                 rst_pin_oe,
  output logic                 wdg_active
);
  import wwdg_pkg::*;

  localparam wwdg_addr_t CTRL_ADDR = wwdg_addr_t'({`WWDG_CTRL_IDX, 2'b00});
  localparam wwdg_addr_t WIN_ADDR  = wwdg_addr_t'({`WWDG_WIN_IDX, 2'b00});

  wwdg_if wif ();

  // option straps come from pins, so two flops before use
  logic [1:0] hw_sync_r;
  logic [1:0] roh_sync_r;
  logic       hw_opt;
  logic       roh_opt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hw_sync_r  <= 2'b00;
      roh_sync_r <= 2'b00;
    end else begin
      hw_sync_r  <= {hw_sync_r[0], hw_wdg_option};
      roh_sync_r <= {roh_sync_r[0], reset_on_halt_option};
    end
  end

  assign hw_opt  = hw_sync_r[1];
  assign roh_opt = roh_sync_r[1];

  // register decode, shared by the read and write paths
  function automatic logic is_reg(input wwdg_addr_t a, input wwdg_addr_t r);
    is_reg = (a == r);
  endfunction : is_reg

  // axi4-lite write side: address and data are latched independently
  logic       aw_hold_r;
  logic       w_hold_r;
  wwdg_addr_t aw_addr_r;
  logic [7:0] w_byte_r;
  logic       w_lane_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       wr_go;
  logic       wr_ctrl;
  logic       wr_win;
  logic       wr_hit;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_go         = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_hit        = is_reg(aw_addr_r, CTRL_ADDR) || is_reg(aw_addr_r, WIN_ADDR);
  assign wr_ctrl       = wr_go && w_lane_r && is_reg(aw_addr_r, CTRL_ADDR);
  assign wr_win        = wr_go && w_lane_r && is_reg(aw_addr_r, WIN_ADDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      w_hold_r <= 1'b0;
      w_byte_r <= '0;
      w_lane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_byte_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  // unmapped addresses answer slverr and change nothing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `WWDG_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `WWDG_RESP_OKAY : `WWDG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // watchdog core state
  logic [6:0]  cnt_r;
  logic [6:0]  cnt_nxt;
  logic [6:0]  win_r;
  logic        act_r;
  logic        active;
  logic        act_after;
  wwdg_state_t state_r;
  wwdg_state_t state_nxt;
  logic [11:0] dly_r;
  logic        dly_done;
  logic        dec;
  logic        fire_roll;
  logic        fire_win;
  logic        fire_sw;
  logic        fire_halt;

  assign active     = act_r || hw_opt;
  assign act_after  = active || (wr_ctrl && w_byte_r[`WWDG_ACT_BIT]);
  assign wdg_active = active;

  // prescaler runs while counting, in WWDG_RUN and WWDG_HALT_DEC only
  assign wif.run = (state_r == WWDG_RUN) || (state_r == WWDG_HALT_DEC);
  assign dec     = wif.tick;

  // a counter write wins over a same-cycle decrement
  assign cnt_nxt = wr_ctrl ? w_byte_r[6:0] : (dec ? cnt_r - 1'b1 : cnt_r);

  // reset causes
  assign fire_roll = active && dec && !wr_ctrl && (state_r == WWDG_RUN)
                     && (cnt_r == `WWDG_ROLL_VAL);
  assign fire_win  = wr_ctrl && active && (cnt_r > win_r);
  assign fire_sw   = wr_ctrl && act_after && !w_byte_r[`WWDG_TOP_BIT];
  assign fire_halt = halt_exec && active && roh_opt && (state_r == WWDG_RUN);
  assign wif.fire  = fire_roll || fire_win || fire_sw || fire_halt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'(`WWDG_CTRL_RST);
      win_r <= `WWDG_WIN_RST;
    end else begin
      cnt_r <= cnt_nxt;
      win_r <= wr_win ? w_byte_r[6:0] : win_r;
    end
  end

  // activation is set-only; a written zero has no effect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_r <= 1'b0;
    end else if (wr_ctrl && w_byte_r[`WWDG_ACT_BIT]) begin
      act_r <= 1'b1;
    end
  end

  // low power sequencing
  assign dly_done = wake_delay_long ? (dly_r == 12'(`WWDG_WAKE_LONG - 1))
                                    : (dly_r == 12'(`WWDG_WAKE_SHORT - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WWDG_RUN: begin
        if (halt_exec && !fire_halt) begin
          state_nxt = clock_timer_irq_enable ? WWDG_ACT_HALT : WWDG_HALT_DEC;
        end
      end
      WWDG_HALT_DEC: begin
        if (ext_irq) begin
          state_nxt = WWDG_WAKE_DLY;
        end else if (dec) begin
          state_nxt = WWDG_HALTED;
        end
      end
      WWDG_HALTED: begin
        if (ext_irq) begin
          state_nxt = WWDG_WAKE_DLY;
        end
      end
      WWDG_WAKE_DLY: begin
        if (dly_done) begin
          state_nxt = WWDG_RUN;
        end
      end
      WWDG_ACT_HALT: begin
        if (ext_irq || osc_irq) begin
          state_nxt = WWDG_RUN;
        end
      end
      default: begin
        state_nxt = WWDG_RUN;
      end
    endcase
  end

  // any reset restarts counting only after the wake delay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= WWDG_WAKE_DLY;
      dly_r   <= '0;
    end else begin
      state_r <= state_nxt;
      dly_r   <= (state_r == WWDG_WAKE_DLY) ? dly_r + 1'b1 : '0;
    end
  end

  // axi4-lite read side, one-cycle answer from flops
  logic       rvalid_r;
  wwdg_word_t rdata_r;
  logic [1:0] rresp_r;
  logic       rd_ctrl;
  logic       rd_win;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_ctrl       = is_reg(s_axi_araddr, CTRL_ADDR);
  assign rd_win        = is_reg(s_axi_araddr, WIN_ADDR);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= `WWDG_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_ctrl ? {24'h000000, act_r, cnt_r}
                : (rd_win ? {25'h0000000, win_r} : 32'h00000000);
      rresp_r  <= (rd_ctrl || rd_win) ? `WWDG_RESP_OKAY : `WWDG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  wwdg_presc #(
    .DIV (PRESC_DIV)
  ) u_presc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pif     (wif.presc)
  );

  wwdg_rstgen u_rstgen (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .rif        (wif.rstgen),
    .rst_pin_o  (rst_pin_o),
    .rst_pin_oe (rst_pin_oe)
  );

  // checks on the core
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_halt_req;
    halt_exec && state_r == WWDG_RUN;
  endsequence

  a_tick_decrement: assert property (
    dec && !wr_ctrl |=> cnt_r == $past(cnt_r) - 7'h01)
    else $error("counter did not step down on tick");
  a_roll_fires: assert property (
    active && dec && !wr_ctrl && state_r == WWDG_RUN && cnt_r == 7'h40
    |=> cnt_r == 7'h3F ##1 rst_pin_oe)
    else $error("roll past 40h gave no reset");
  a_window_reset: assert property (
    wr_ctrl && active && cnt_r > win_r |=> ##1 rst_pin_oe)
    else $error("early reload gave no reset");
  a_disabled_quiet: assert property (
    !active && !wr_ctrl |-> !wif.fire)
    else $error("reset while watchdog disabled");
  a_act_sticky: assert property (
    act_r |=> act_r)
    else $error("activation bit cleared without reset");
  a_hw_active: assert property (
    hw_opt |-> wdg_active)
    else $error("hardware option not active");
  a_sw_reset: assert property (
    wr_ctrl && act_after && !w_byte_r[6] |-> wif.fire ##2 rst_pin_oe)
    else $error("top bit clear gave no reset");
  a_halt_reset: assert property (
    s_halt_req and (active && roh_opt) |-> wif.fire ##1 state_r == WWDG_RUN)
    else $error("halt with reset-on-halt misbehaved");
  a_act_halt_frozen: assert property (
    state_r == WWDG_ACT_HALT && !wr_ctrl |=> $stable(cnt_r) || state_r == WWDG_RUN)
    else $error("counter moved in active halt");
  a_halt_one_step: assert property (
    state_r == WWDG_HALTED && !ext_irq && !wr_ctrl |=> $stable(cnt_r) && !wif.fire)
    else $error("counter moved in halt");

  // bus handshake and low-power checks; the wake and halt steps are paths
  // that ordinary register traffic never exercises, so they get their own
  sequence s_act_wake;
    state_r == WWDG_ACT_HALT && (ext_irq || osc_irq);
  endsequence

  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_bvalid_follows: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_window_lands: assert property (
    wr_win |=> {1'b0, win_r} == ($past(w_byte_r) & 8'h7F))
    else $error("window write lost");
  a_wake_frozen: assert property (
    state_r == WWDG_WAKE_DLY && !wr_ctrl |=> $stable(cnt_r))
    else $error("counter moved during wake delay");
  a_halt_dec_once: assert property (
    state_r == WWDG_HALT_DEC && dec && !wr_ctrl |=> state_r == WWDG_HALTED || state_r == WWDG_WAKE_DLY)
    else $error("halt did not stop after one step");
  a_act_wake_run: assert property (
    s_act_wake |=> state_r == WWDG_RUN && wif.run)
    else $error("active halt wake did not resume");
endmodule : wwdg_top

// [tb/wwdg_tb.sv]
`timescale 1ns/1ns
`include "wwdg_cfg.svh"
module testbench;
  import wwdg_pkg::*;
  localparam int         DIV  = 16;
  localparam wwdg_addr_t CTRL = `WWDG_CTRL_IDX << 2;
  localparam wwdg_addr_t WIN  = `WWDG_WIN_IDX << 2;
  localparam wwdg_addr_t BAD  = 8'h10;
  logic       ref_clk, rst, awv, wv, bre, arv, rre, hw, roh, halt, ctie, eirq, oirq, wdl;
  logic       awr, wr_rdy, bv, arr, rv, pin, oe, act, oe_seen;
  logic [1:0] br, rr;
  wwdg_addr_t aw, ar;
  wwdg_word_t wd, rd;
  int         run, last_len, cyc, n_mismatch, n_compared;

  // short prescaler keeps each roll-over scenario near a thousand cycles
  wwdg_top #(.PRESC_DIV(DIV)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .hw_wdg_option(hw),
    .reset_on_halt_option(roh), .halt_exec(halt), .clock_timer_irq_enable(ctie),
    .ext_irq(eirq), .osc_irq(oirq), .wake_delay_long(wdl), .rst_pin_o(pin),
    .rst_pin_oe(oe), .wdg_active(act));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // pulse watcher on the falling edge, where the pin output has settled
  always @(negedge ref_clk) begin
    if (oe === 1'b1) begin
      run = run + 1;
      oe_seen = 1'b1;
    end else if (run != 0) begin
      last_len = run;
      run = 0;
    end
  end

  // hang guard, well above the sum of all scenarios
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // address and data offered together, each dropped at the edge that takes it
  task automatic wr(input wwdg_addr_t a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, sa, sw, sb;
    @(posedge ref_clk);
    aw <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    sb = 1'b0;
    while (!(ta && tw)) begin
      @(negedge ref_clk);
      sa = !ta && awr;
      sw = !tw && wr_rdy;
      @(posedge ref_clk);
      if (sa) begin
        awv <= 1'b0;
        ta = 1'b1;
      end
      if (sw) begin
        wv <= 1'b0;
        tw = 1'b1;
      end
    end
    while (!sb) begin
      @(negedge ref_clk);
      sb = bv;
      if (sb) chk("bresp", {30'h0, er}, {30'h0, br});
      @(posedge ref_clk);
    end
    bre <= 1'b0;
  endtask : wr

  task automatic rdv(input wwdg_addr_t a, input logic [1:0] er, output logic [7:0] v);
    logic sa, sr;
    @(posedge ref_clk);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    sr = 1'b0;
    while (!sr) begin
      @(negedge ref_clk);
      sa = arv && arr;
      sr = rv;
      if (sr) chk("rresp", {30'h0, er}, {30'h0, rr});
      if (sr) chk("rdata_upper", 32'h0, {rd[31:8], 8'h0});
      v = rd[7:0];
      @(posedge ref_clk);
      if (sa) arv <= 1'b0;
    end
    arv <= 1'b0;
    rre <= 1'b0;
  endtask : rdv

  task automatic do_reset(input logic h, input logic r);
    @(posedge ref_clk);
    hw <= h;
    roh <= r;
    ctie <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    oe_seen = 1'b0;
  endtask : do_reset

  task automatic pulse_halt();
    @(posedge ref_clk);
    halt <= 1'b1;
    @(posedge ref_clk);
    halt <= 1'b0;
  endtask : pulse_halt

  // reset pin must be pulled within the limit, for the full pulse length
  task automatic expect_fire(input int limit);
    int n;
    n = 0;
    while (!oe_seen && n < limit) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk("fire", 1, oe_seen);
    chk("pin_level", 0, pin);
    n = 0;
    while (oe !== 1'b0 && n < 700) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    repeat (2) @(negedge ref_clk);
    chk("pulse_len", `WWDG_RST_PULSE_CYC, last_len);
  endtask : expect_fire

  task automatic t_reset();
    logic [7:0] v;
    rdv(CTRL, `WWDG_RESP_OKAY, v);
    chk("ctrl_rst", `WWDG_CTRL_RST, v);
    rdv(WIN, `WWDG_RESP_OKAY, v);
    chk("win_rst", 32'h7F, v);
    rdv(BAD, `WWDG_RESP_SLVERR, v);
    chk("bad_rdata", 0, v);
    wr(BAD, 8'hFF, `WWDG_RESP_SLVERR);
    chk("active_rst", 0, act);
  endtask : t_reset

  task automatic t_free();
    logic [7:0] v;
    repeat (`WWDG_WAKE_SHORT + DIV * 70) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, v);
    chk("free_run", 1, v[6:0] < 7'h3F);
    chk("no_fire_off", 0, oe_seen);
  endtask : t_free

  task automatic t_window();
    do_reset(1'b0, 1'b0);
    wr(WIN, 8'h50, `WWDG_RESP_OKAY);
    wr(CTRL, 8'hFF, `WWDG_RESP_OKAY);
    chk("enabled", 1, act);
    chk("no_fire_en", 0, oe_seen);
    wr(CTRL, 8'h7F, `WWDG_RESP_OKAY);
    chk("stay_on", 1, act);
    expect_fire(4);
  endtask : t_window

  task automatic t_inwin();
    do_reset(1'b0, 1'b0);
    wr(CTRL, 8'hFF, `WWDG_RESP_OKAY);
    wr(CTRL, 8'h7F, `WWDG_RESP_OKAY);
    repeat (4) @(posedge ref_clk);
    chk("refresh_ok", 0, oe_seen);
    chk("stay_on2", 1, act);
    wr(CTRL, 8'hBF, `WWDG_RESP_OKAY);
    expect_fire(4);
  endtask : t_inwin

  task automatic t_roll();
    do_reset(1'b0, 1'b0);
    repeat (`WWDG_WAKE_SHORT) @(posedge ref_clk);
    wr(CTRL, 8'hC1, `WWDG_RESP_OKAY);
    wr(CTRL, 8'hC1, `WWDG_RESP_OKAY);
    repeat (DIV - 4) @(posedge ref_clk);
    chk("no_early", 0, oe_seen);
    expect_fire(DIV + 8);
  endtask : t_roll

  task automatic t_hw();
    do_reset(1'b1, 1'b0);
    chk("hw_active", 1, act);
    wr(CTRL, 8'h3F, `WWDG_RESP_OKAY);
    expect_fire(4);
  endtask : t_hw

  task automatic t_roh();
    do_reset(1'b0, 1'b1);
    // the cpu only runs, and so only halts, once the wake delay is over
    repeat (`WWDG_WAKE_SHORT) @(posedge ref_clk);
    wr(CTRL, 8'hFF, `WWDG_RESP_OKAY);
    pulse_halt();
    expect_fire(4);
  endtask : t_roh

  task automatic t_ahalt();
    logic [7:0] a, b;
    do_reset(1'b0, 1'b0);
    repeat (`WWDG_WAKE_SHORT) @(posedge ref_clk);
    ctie <= 1'b1;
    wr(CTRL, 8'hC1, `WWDG_RESP_OKAY);
    pulse_halt();
    rdv(CTRL, `WWDG_RESP_OKAY, a);
    repeat (4 * DIV) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, b);
    chk("frozen_ah", a, b);
    chk("no_fire_ah", 0, oe_seen);
    @(posedge ref_clk);
    oirq <= 1'b1;
    @(posedge ref_clk);
    oirq <= 1'b0;
    expect_fire(2 * DIV + 8);
  endtask : t_ahalt

  task automatic t_halt();
    logic [7:0] a, b;
    do_reset(1'b0, 1'b0);
    repeat (`WWDG_WAKE_SHORT) @(posedge ref_clk);
    wr(CTRL, 8'hC2, `WWDG_RESP_OKAY);
    pulse_halt();
    repeat (2 * DIV) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, a);
    chk("one_dec", 1, a[6:0] == 7'h41 || a[6:0] == 7'h40);
    repeat (4 * DIV) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, b);
    chk("frozen_h", a, b);
    chk("no_fire_h", 0, oe_seen);
    @(posedge ref_clk);
    eirq <= 1'b1;
    @(posedge ref_clk);
    eirq <= 1'b0;
    repeat (200) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, b);
    chk("wake_delay", a, b);
    expect_fire(60 + 2 * DIV);
    do_reset(1'b0, 1'b0);
    chk("off_after", 0, act);
  endtask : t_halt

  // long wake delay: counter must stay frozen well past the short delay
  task automatic t_long();
    logic [7:0] v;
    wdl <= 1'b1;
    do_reset(1'b0, 1'b0);
    repeat (`WWDG_WAKE_SHORT + 4 * DIV) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, v);
    chk("long_frozen", `WWDG_CTRL_RST, v);
    repeat (`WWDG_WAKE_LONG) @(posedge ref_clk);
    rdv(CTRL, `WWDG_RESP_OKAY, v);
    chk("long_resumed", 1, v < 8'h7F);
    wdl <= 1'b0;
  endtask : t_long

  initial begin
    {awv, wv, bre, arv, rre, hw, roh, halt, ctie, eirq, oirq, wdl} = '0;
    aw = '0;
    ar = '0;
    wd = '0;
    rst = 1'b1;
    oe_seen = 1'b0;
    {run, last_len, cyc, n_mismatch, n_compared} = '0;
    do_reset(1'b0, 1'b0);
    t_reset();
    t_free();
    t_window();
    t_inwin();
    t_roll();
    t_hw();
    t_roh();
    t_ahalt();
    t_halt();
    t_long();
    conclude();
  end
endmodule : testbench
